// ### rtl/dmm_core.sv
// Purpose: Data-space decoder, extended SRAM, external bus strobes, internal RAM and stack
// Assumes: Core issues at most one request class per cycle; flash size static
// Notes: Flash data contents live outside; this block only steers to it
//
// Functional notes
// - Addresses 0000h-03FFh hit 1 KB SRAM
// - Flash data region starts at 0400h
// - Above flash goes external, except relocated SRAM
// - Data move reaches all but internal RAM
// - 64 KB space, at most 33 KB on-chip
// - External access drives ports 0/2 and strobes
// - 256 byte internal RAM, not initialised
// - Bank 0 at 00h, banks 1-3 to 1Fh
// - Working register address is 8*bank plus n
// - Reset selects working-register bank 0
// - Bit memory lives at bytes 20h-2Fh
// - Upper 128 bytes reachable only indirectly
// - Stack pointer is 8-bit RAM address
// - Pop reads then decrements pointer
// - Push increments pointer then writes
// - Stack pointer resets to 07h
// - Stack holds returns and pushed values
// - Control bit 0 relocates SRAM to 8400h
`timescale 1ns/1ps
`default_nettype none
module dmm_core
    import dmm_pkg::*;
#(
    parameter int XSRAM_DEPTH = DMM_XSRAM_DEPTH,
    parameter int IRAM_DEPTH = DMM_IRAM_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire dmm_xreq_t XREQ,
    input wire dmm_ireq_t IREQ,
    input wire dmm_stack_t STACK_OP,
    input wire logic [1:0] BANK_SEL,
    input wire logic BANK_WRITE,
    input wire logic [7:0] MEMORY_CONTROL_REG,
    input wire logic [15:0] FLASH_DATA_SIZE,
    input wire logic [7:0] FLASH_RDATA,
    input wire logic [7:0] P0_IN,
    output logic [7:0] XRDATA,
    output logic XRVALID,
    output logic FLASH_REQ,
    output logic FLASH_WRITE,
    output logic [15:0] FLASH_ADDR,
    output logic [7:0] FLASH_WDATA,
    output logic [7:0] IRDATA,
    output logic IRVALID,
    output logic IERR,
    output logic [7:0] STACK_POINTER,
    output logic [1:0] BANK,
    output logic [7:0] P0_OUT,
    output logic P0_OE,
    output logic [7:0] P2_OUT,
    output logic ALE,
    output logic RD_N,
    output logic WR_N
);
    // External bus phases: address, strobe, release
    typedef enum logic [1:0] {
        DMM_BUS_IDLE,
        DMM_BUS_ADDR,
        DMM_BUS_STROBE,
        DMM_BUS_DONE
    } dmm_bus_t;

    typedef struct packed {
        logic [7:0] stack_pointer;
        logic [1:0] bank;
        dmm_bus_t bus;
        logic bus_write;
        logic [15:0] bus_addr;
        logic [7:0] bus_wdata;
        logic flash_pend;
        logic [7:0] xrdata;
        logic xrvalid;
        logic flash_req;
        logic flash_write;
        logic [15:0] flash_addr;
        logic [7:0] flash_wdata;
        logic [7:0] irdata;
        logic irvalid;
        logic ierr;
        logic [7:0] p0_out;
        logic p0_oe;
        logic [7:0] p2_out;
        logic ale;
        logic rd_n;
        logic wr_n;
    } dmm_state_t;

    dmm_state_t st;
    dmm_state_t next_st;

    logic [7:0] xsram [XSRAM_DEPTH];
    // Internal RAM, no reset so contents start undefined
    logic [7:0] iram [IRAM_DEPTH];

    logic reloc;
    logic [15:0] sram_base;
    logic [15:0] flash_end;
    logic [15:0] xoff;
    dmm_target_t target;
    logic [7:0] iaddr;
    logic [7:0] sp_inc;
    logic [7:0] sp_dec;
    logic xsram_we;
    logic iram_we;
    logic [7:0] iram_wa;
    logic [7:0] iram_wd;

    // Relocation bit moves only the SRAM window
    assign reloc = MEMORY_CONTROL_REG[DMM_MEMORY_CONTROL_REG_RELOC_BIT];
    assign sram_base = reloc ? DMM_XSRAM_HIGH_BASE : DMM_XSRAM_LOW_BASE;
    // Static size bounds the flash window; capped at 32 KB
    assign flash_end = DMM_FLASH_BASE + ((FLASH_DATA_SIZE > DMM_FLASH_MAX_SIZE) ?
        DMM_FLASH_MAX_SIZE : FLASH_DATA_SIZE);
    assign xoff = XREQ.addr - sram_base;
    assign sp_inc = st.stack_pointer + 8'h01;
    assign sp_dec = st.stack_pointer - 8'h01;

    // ********************************************
    // Data-space decode
    // ********************************************
    // Address decode; SRAM wins so a relocated window is never shadowed
    always_comb begin
        if (XREQ.addr >= sram_base && XREQ.addr < sram_base + DMM_XSRAM_SPAN) begin
            target = DMM_TGT_SRAM;
        end else if (XREQ.addr >= DMM_FLASH_BASE && XREQ.addr < flash_end) begin
            target = DMM_TGT_FLASH;
        end else begin
            target = DMM_TGT_EXT;
        end
    end

    // Working register maps to 8*bank + n
    assign iaddr = IREQ.use_reg ? {3'h0, st.bank, IREQ.reg_num} : IREQ.addr;

    always_comb begin
        xsram_we = 1'b0;
        iram_we = 1'b0;
        iram_wa = iaddr;
        iram_wd = IREQ.wdata;
        // Push writes at the already incremented pointer
        if (STACK_OP.push) begin
            iram_we = 1'b1;
            iram_wa = sp_inc;
            iram_wd = STACK_OP.wdata;
        // Direct writes above 7Fh never reach RAM
        end else if (IREQ.valid && IREQ.write &&
                (IREQ.indirect || IREQ.use_reg || iaddr <= DMM_DIRECT_LIMIT)) begin
            iram_we = 1'b1;
        end
        // Data move writes on-chip SRAM here, never internal RAM
        if (XREQ.valid && XREQ.write && target == DMM_TGT_SRAM && st.bus == DMM_BUS_IDLE) begin
            xsram_we = 1'b1;
        end
    end

    // ********************************************
    // Next state: stack, internal RAM, bus phases
    // ********************************************
    always_comb begin
        next_st = st;
        next_st.xrvalid = 1'b0;
        next_st.irvalid = 1'b0;
        next_st.ierr = 1'b0;
        next_st.flash_req = 1'b0;
        next_st.flash_pend = 1'b0;
        if (BANK_WRITE) begin
            next_st.bank = BANK_SEL;
        end
        // Pop reads the top byte then decrements
        if (STACK_OP.pop) begin
            next_st.irdata = iram[st.stack_pointer];
            next_st.irvalid = 1'b1;
            next_st.stack_pointer = sp_dec;
        end else if (STACK_OP.push) begin
            next_st.stack_pointer = sp_inc;
        end else if (IREQ.valid && !IREQ.write) begin
            // Bit bytes 20h-2Fh are ordinary RAM bytes
            if (!IREQ.indirect && !IREQ.use_reg && iaddr > DMM_DIRECT_LIMIT) begin
                next_st.ierr = 1'b1;
            end else begin
                next_st.irdata = iram[iaddr];
                next_st.irvalid = 1'b1;
            end
        end else if (IREQ.valid && !IREQ.indirect && !IREQ.use_reg &&
                iaddr > DMM_DIRECT_LIMIT) begin
            next_st.ierr = 1'b1;
        end
        if (st.flash_pend) begin
            next_st.xrdata = FLASH_RDATA;
            next_st.xrvalid = !st.flash_write;
        end
        case (st.bus)
            DMM_BUS_IDLE: begin
                if (XREQ.valid) begin
                    case (target)
                        DMM_TGT_SRAM: begin
                            next_st.xrdata = xsram[xoff[9:0]];
                            next_st.xrvalid = !XREQ.write;
                        end
                        DMM_TGT_FLASH: begin
                            next_st.flash_req = 1'b1;
                            next_st.flash_pend = 1'b1;
                            next_st.flash_write = XREQ.write;
                            next_st.flash_addr = XREQ.addr - DMM_FLASH_BASE;
                            next_st.flash_wdata = XREQ.wdata;
                        end
                        default: begin
                            // Low address on port 0, high on port 2, latch pulse
                            next_st.bus = DMM_BUS_ADDR;
                            next_st.bus_write = XREQ.write;
                            next_st.bus_addr = XREQ.addr;
                            next_st.bus_wdata = XREQ.wdata;
                            next_st.p0_out = XREQ.addr[7:0];
                            next_st.p0_oe = 1'b1;
                            next_st.p2_out = XREQ.addr[15:8];
                            next_st.ale = 1'b1;
                        end
                    endcase
                end
            end
            DMM_BUS_ADDR: begin
                // Drop latch and start read or write strobe in the same cycle
                next_st.bus = DMM_BUS_STROBE;
                next_st.ale = 1'b0;
                next_st.p0_oe = st.bus_write;
                next_st.p0_out = st.bus_wdata;
                next_st.rd_n = st.bus_write;
                next_st.wr_n = !st.bus_write;
            end
            DMM_BUS_STROBE: begin
                next_st.bus = DMM_BUS_DONE;
                next_st.rd_n = 1'b1;
                next_st.wr_n = 1'b1;
                if (!st.bus_write) begin
                    next_st.xrdata = P0_IN;
                    next_st.xrvalid = 1'b1;
                end
            end
            DMM_BUS_DONE: begin
                // Release port 0 a cycle after strobe so data hold is met
                next_st.bus = DMM_BUS_IDLE;
                next_st.p0_oe = 1'b0;
            end
            default: begin
                next_st.bus = DMM_BUS_IDLE;
            end
        endcase
    end

    // ********************************************
    // State and storage
    // ********************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            st <= '0;
            st.stack_pointer <= DMM_SP_RESET;
            st.bank <= DMM_BANK_RESET;
            st.bus <= DMM_BUS_IDLE;
            st.rd_n <= 1'b1;
            st.wr_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Banks 0-3 are plain RAM bytes 00h-1Fh
    always_ff @(posedge CLOCK) begin
        if (iram_we) begin
            iram[iram_wa] <= iram_wd;
        end
        if (xsram_we) begin
            xsram[xoff[9:0]] <= XREQ.wdata;
        end
    end

    assign XRDATA = st.xrdata;
    assign XRVALID = st.xrvalid;
    assign FLASH_REQ = st.flash_req;
    assign FLASH_WRITE = st.flash_write;
    assign FLASH_ADDR = st.flash_addr;
    assign FLASH_WDATA = st.flash_wdata;
    assign IRDATA = st.irdata;
    assign IRVALID = st.irvalid;
    assign IERR = st.ierr;
    assign STACK_POINTER = st.stack_pointer;
    assign BANK = st.bank;
    assign P0_OUT = st.p0_out;
    assign P0_OE = st.p0_oe;
    assign P2_OUT = st.p2_out;
    assign ALE = st.ale;
    assign RD_N = st.rd_n;
    assign WR_N = st.wr_n;
endmodule : dmm_core
`default_nettype wire

// ### rtl/dmm_pkg.sv
// Purpose: Shared constants and carriers for the data memory map and stack block
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes: Addresses are byte addresses in the 16-bit data space or 8-bit internal RAM
package dmm_pkg;
    localparam int DMM_XADDR_W = 16;
    localparam int DMM_IADDR_W = 8;
    localparam int DMM_DATA_W = 8;
    localparam int DMM_XSRAM_DEPTH = 1024;
    localparam int DMM_IRAM_DEPTH = 256;
    localparam logic [15:0] DMM_XSRAM_LOW_BASE = 16'h0000;
    localparam logic [15:0] DMM_XSRAM_HIGH_BASE = 16'h8400;
    localparam logic [15:0] DMM_FLASH_BASE = 16'h0400;
    localparam logic [15:0] DMM_XSRAM_SPAN = 16'h0400;
    localparam logic [15:0] DMM_FLASH_MAX_SIZE = 16'h8000;
    localparam logic [7:0] DMM_SP_RESET = 8'h07;
    localparam logic [1:0] DMM_BANK_RESET = 2'h0;
    localparam logic [7:0] DMM_DIRECT_LIMIT = 8'h7F;
    localparam logic [7:0] DMM_BIT_BYTE_BASE = 8'h20;
    localparam logic [7:0] DMM_BIT_BYTE_LAST = 8'h2F;
    localparam int DMM_MEMORY_CONTROL_REG_RELOC_BIT = 0;

    // Where an external-data-move lands
    typedef enum logic [1:0] {
        DMM_TGT_SRAM,
        DMM_TGT_FLASH,
        DMM_TGT_EXT
    } dmm_target_t;

    // External-data-move request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dmm_xreq_t;

    // Internal RAM request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic indirect;
        logic use_reg;
        logic [2:0] reg_num;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmm_ireq_t;

    // Stack operation
    typedef struct packed {
        logic push;
        logic pop;
        logic [7:0] wdata;
    } dmm_stack_t;
endpackage : dmm_pkg

// ### bench/dmm_checker.sv
// Purpose: Port-level assertions for the data memory map and stack block
// Assumes: One clock, synchronous active-high reset
// Notes: Bus idle is required before a data-move request is judged
`timescale 1ns/1ps
`default_nettype none
module dmm_checker
    import dmm_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire dmm_xreq_t XREQ,
    input wire dmm_ireq_t IREQ,
    input wire dmm_stack_t STACK_OP,
    input wire logic [1:0] BANK_SEL,
    input wire logic BANK_WRITE,
    input wire logic [7:0] MEMORY_CONTROL_REG,
    input wire logic [15:0] FLASH_DATA_SIZE,
    input wire logic XRVALID,
    input wire logic FLASH_REQ,
    input wire logic [15:0] FLASH_ADDR,
    input wire logic IERR,
    input wire logic [7:0] STACK_POINTER,
    input wire logic [1:0] BANK,
    input wire logic [7:0] P0_OUT,
    input wire logic P0_OE,
    input wire logic [7:0] P2_OUT,
    input wire logic ALE,
    input wire logic RD_N,
    input wire logic WR_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    logic sram_hit, flash_hit, ext_hit, xtake;
    logic [15:0] flash_end;
    assign flash_end = DMM_FLASH_BASE + FLASH_DATA_SIZE;
    assign sram_hit = MEMORY_CONTROL_REG[DMM_MEMORY_CONTROL_REG_RELOC_BIT]
        ? (XREQ.addr >= 16'h8400 && XREQ.addr <= 16'h87FF) : (XREQ.addr < 16'h0400);
    assign flash_hit = !sram_hit && XREQ.addr >= DMM_FLASH_BASE && XREQ.addr < flash_end;
    assign ext_hit = !sram_hit && XREQ.addr >= flash_end;
    logic [1:0] ale_hist;
    // Latch pulse history: the bus stays busy for three cycles after a request
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ale_hist <= '0;
        end else begin
            ale_hist <= {ale_hist[0], ALE};
        end
    end
    // Only judged with the bus idle, since busy requests are dropped
    assign xtake = XREQ.valid && !ALE && ale_hist == 2'h0 && RD_N && WR_N && !P0_OE;
    // ****
    // Bus phases
    // ****
    sequence addr_phase;
        ALE && P0_OE && P0_OUT == $past(XREQ.addr[7:0]) && P2_OUT == $past(XREQ.addr[15:8]);
    endsequence
    sequence read_phase;
        !ALE && !RD_N && !P0_OE ##1 RD_N && XRVALID;
    endsequence
    sequence write_phase;
        !WR_N && P0_OE && P0_OUT == $past(XREQ.wdata, 2) ##1 WR_N;
    endsequence
    reset_state_a: assert property (
        $past(RESET) |-> STACK_POINTER == DMM_SP_RESET && BANK == DMM_BANK_RESET)
        else $error("bad state after reset");
    push_step_a: assert property (
        STACK_OP.push |=> STACK_POINTER == $past(STACK_POINTER) + 8'h01)
        else $error("push did not step pointer up");
    pop_step_a: assert property (
        STACK_OP.pop && !STACK_OP.push |=> STACK_POINTER == $past(STACK_POINTER) - 8'h01)
        else $error("pop did not step pointer down");
    direct_limit_a: assert property (
        IREQ.valid && !IREQ.indirect && !IREQ.use_reg && IREQ.addr > DMM_DIRECT_LIMIT |=> IERR)
        else $error("direct upper access not refused");
    bank_load_a: assert property (BANK_WRITE |=> BANK == $past(BANK_SEL))
        else $error("bank not loaded");
    sram_read_a: assert property (
        xtake && !XREQ.write && sram_hit |=> XRVALID && !ALE && !FLASH_REQ)
        else $error("sram read misrouted");
    flash_read_a: assert property (
        xtake && !XREQ.write && flash_hit
        |=> FLASH_REQ && FLASH_ADDR == $past(XREQ.addr) - DMM_FLASH_BASE ##1 XRVALID)
        else $error("flash read misrouted");
    ext_read_a: assert property (
        xtake && !XREQ.write && ext_hit |=> addr_phase ##1 read_phase)
        else $error("external read cycle wrong");
    ext_write_a: assert property (
        xtake && XREQ.write && ext_hit |=> addr_phase ##1 write_phase)
        else $error("external write cycle wrong");
endmodule : dmm_checker
bind dmm_core dmm_checker chk_u (.CLOCK(CLOCK), .RESET(RESET), .XREQ(XREQ), .IREQ(IREQ),
    .STACK_OP(STACK_OP), .BANK_SEL(BANK_SEL), .BANK_WRITE(BANK_WRITE),
    .MEMORY_CONTROL_REG(MEMORY_CONTROL_REG), .FLASH_DATA_SIZE(FLASH_DATA_SIZE),
    .XRVALID(XRVALID), .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR), .IERR(IERR),
    .STACK_POINTER(STACK_POINTER), .BANK(BANK), .P0_OUT(P0_OUT), .P0_OE(P0_OE),
    .P2_OUT(P2_OUT), .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N));
`default_nettype wire

// ### bench/dmm_xmem_model.sv
// Purpose: External memory on the multiplexed port 0/2 bus
// Assumes: Strobes sampled on the core clock
// Notes: No wait states exist on this bus
`timescale 1ns/1ps
`default_nettype none
module dmm_xmem_model (
    input wire logic clock,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p2_out,
    output logic [7:0] p0_in
);
    logic [7:0] mem [0:65535];
    logic [15:0] latch_addr;
    logic [7:0] last = 8'h00;
    always_ff @(posedge clock) begin
        if (ale) latch_addr <= {p2_out, p0_out};
        if (!wr_n) mem[latch_addr] <= p0_out;
        if (!rd_n) last <= mem[latch_addr];
    end
    // Released bus shows the inverse, so stale data never matches
    assign p0_in = !rd_n ? mem[latch_addr] : ~last;
endmodule : dmm_xmem_model
`default_nettype wire

// ### bench/dmm_core_bench.sv
// Purpose: Self-checking bench for the data memory map and stack block
// Assumes: External bus answered by the memory model
// Notes: Flash data size is 0800h, so external space starts at 0C00h
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module dmm_core_bench;
    import dmm_pkg::*;
    int failures = 0, n_checks = 0, n;
    logic clock = 0, reset = 1, bank_write = 0;
    dmm_xreq_t xreq = '0;
    dmm_ireq_t ireq = '0;
    dmm_stack_t stack_op = '0;
    logic [1:0] bank_sel = '0, bank;
    logic [7:0] mcr = '0, flash_rdata = 8'h5A, p0_in, xrdata, irdata, sp, p0_out, p2_out;
    logic [15:0] flash_size = 16'h0800, flash_addr;
    logic [7:0] flash_wdata;
    logic xrvalid, flash_req, flash_write, irvalid, ierr, p0_oe, ale, rd_n, wr_n;
    logic [15:0] ext_tab [3] = '{16'h0C00, 16'h8400, 16'hFFFF};
    always #2 clock = ~clock;
    dmm_core dut_u (.CLOCK(clock), .RESET(reset), .XREQ(xreq), .IREQ(ireq), .STACK_OP(stack_op),
        .BANK_SEL(bank_sel), .BANK_WRITE(bank_write), .MEMORY_CONTROL_REG(mcr),
        .FLASH_DATA_SIZE(flash_size), .FLASH_RDATA(flash_rdata), .P0_IN(p0_in),
        .XRDATA(xrdata), .XRVALID(xrvalid), .FLASH_REQ(flash_req), .FLASH_WRITE(flash_write),
        .FLASH_ADDR(flash_addr), .FLASH_WDATA(flash_wdata), .IRDATA(irdata), .IRVALID(irvalid),
        .IERR(ierr), .STACK_POINTER(sp), .BANK(bank), .P0_OUT(p0_out), .P0_OE(p0_oe),
        .P2_OUT(p2_out), .ALE(ale), .RD_N(rd_n), .WR_N(wr_n));
    dmm_xmem_model xmem_u (.clock(clock), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .p0_out(p0_out), .p2_out(p2_out), .p0_in(p0_in));
    task automatic test_done;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Writes wait out the four-cycle bus slot; reads count cycles to the answer
    task automatic xacc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock) xreq <= '{1'b1, wr, a, d};
        @(posedge clock) xreq.valid <= 1'b0;
        #1;
        n = 1;
        if (wr) begin
            repeat (4) @(posedge clock);
        end else begin
            while (xrvalid !== 1'b1 && n < 6) begin
                @(posedge clock) #1;
                n++;
            end
            if (xrvalid !== 1'b1) begin
                `CHK(xrvalid, 1'b1)
                test_done;
            end
        end
    endtask : xacc
    // Returns just after the taking edge, while the answer pulses still stand
    task automatic iacc(input logic wr, ind, ureg, input logic [7:0] a, d);
        @(posedge clock) ireq <= '{1'b1, wr, ind, ureg, 3'd4, a, d};
        @(posedge clock) ireq.valid <= 1'b0;
        #1;
    endtask : iacc
    task automatic stk(input logic push, input logic [7:0] d);
        @(posedge clock) stack_op <= '{push, !push, d};
        @(posedge clock) stack_op <= '0;
        @(posedge clock) #1;
    endtask : stk
    task automatic t_stack;
        `CHK(sp, DMM_SP_RESET)
        `CHK(bank, DMM_BANK_RESET)
        stk(1'b1, 8'h11);
        stk(1'b1, 8'h22);
        `CHK(sp, 8'h09)
        iacc(1'b0, 1'b0, 1'b0, 8'h08, 8'h00);
        `CHK(irdata, 8'h11)
        stk(1'b0, 8'h00);
        `CHK(irdata, 8'h22)
        `CHK(sp, 8'h08)
        $display("stack test done");
    endtask : t_stack
    task automatic t_iram;
        @(posedge clock) {bank_sel, bank_write} <= {2'd2, 1'b1};
        @(posedge clock) bank_write <= 1'b0;
        iacc(1'b1, 1'b0, 1'b1, 8'h00, 8'h44);
        iacc(1'b0, 1'b0, 1'b0, 8'h14, 8'h00);
        `CHK(irdata, 8'h44)
        `CHK(irvalid, 1'b1)
        iacc(1'b1, 1'b1, 1'b0, 8'h80, 8'h77);
        iacc(1'b1, 1'b0, 1'b0, 8'h80, 8'h11);
        `CHK(ierr, 1'b1)
        iacc(1'b0, 1'b1, 1'b0, 8'h80, 8'h00);
        `CHK(irdata, 8'h77)
        $display("internal ram test done");
    endtask : t_iram
    // A mid-run reset restores pointer and bank but leaves RAM alone
    task automatic t_reset;
        @(posedge clock) reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock) #1;
        `CHK(sp, DMM_SP_RESET)
        `CHK(bank, DMM_BANK_RESET)
        iacc(1'b0, 1'b1, 1'b0, 8'h80, 8'h00);
        `CHK(irdata, 8'h77)
        $display("reset test done");
    endtask : t_reset
    task automatic t_xmem;
        xacc(1'b1, 16'h03FF, 8'hC3);
        xacc(1'b0, 16'h03FF, 8'h00);
        `CHK(n, 1)
        `CHK(xrdata, 8'hC3)
        @(posedge clock) mcr <= 8'h01;
        xacc(1'b0, 16'h87FF, 8'h00);
        `CHK(xrdata, 8'hC3)
        @(posedge clock) mcr <= 8'h00;
        xacc(1'b1, 16'h0400, 8'h3C);
        `CHK(flash_write, 1'b1)
        `CHK(flash_addr, 16'h0000)
        `CHK(flash_wdata, 8'h3C)
        xacc(1'b0, 16'h0BFF, 8'h00);
        `CHK(n, 2)
        `CHK(flash_addr, 16'h07FF)
        `CHK(xrdata, flash_rdata)
        foreach (ext_tab[i]) begin
            xacc(1'b1, ext_tab[i], ext_tab[i][7:0] ^ 8'hA5);
            xacc(1'b0, ext_tab[i], 8'h00);
            `CHK(n, 3)
            `CHK(xrdata, ext_tab[i][7:0] ^ 8'hA5)
        end
        $display("data move test done");
    endtask : t_xmem
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock) #1;
        t_stack;
        t_iram;
        t_reset;
        t_xmem;
        test_done;
    end
endmodule : dmm_core_bench
`default_nettype wire
